// *** hdl/asc_ctrl.sv ***
// Purpose: Host controller that drives an asynchronous 8-bit memory.
// Assumes: Requests come from logic on mclk; read data arrive on pins.
// Notes:   Writes run with the output gate high.
//
// Overview of operation
// - Read: strobe high, selected, output gate low.
// - Keep data setup and hold at ending edge.
// - Address valid no later than select rises.
// - Strobe low at least float plus setup.
// - Never drive data while memory drives.
// - Back-to-back reads change only the address.
`timescale 1ns/1ps
module asc_ctrl (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        req_valid,
	input  wire logic                        req_write,
	input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
	input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
	output wire logic                        req_ready,
	output wire logic                        rsp_valid,
	output wire logic [asc_pkg::DATA_W-1:0]  rsp_rdata,
	output wire logic                        chip_select_low_n,
	output wire logic                        chip_select_high,
	output wire logic                        write_strobe_n,
	output wire logic                        output_gate_n,
	output wire logic [asc_pkg::ADDR_W-1:0]  mem_addr,
	output wire logic [asc_pkg::DATA_W-1:0]  mem_data_out,
	output wire logic                        mem_data_oe_n,
	input  wire logic [asc_pkg::DATA_W-1:0]  mem_data_in
);
	logic                        rst_meta_q;
	logic                        rst_sync_q;
	asc_pkg::asc_state_t         state_q;
	logic                        ready_q;
	logic                        accept;
	logic                        sel_q;
	logic                        sel_n_q;
	logic                        we_n_q;
	logic                        gate_n_q;
	logic                        doe_n_q;
	logic [asc_pkg::ADDR_W-1:0]  addr_q;
	logic [asc_pkg::DATA_W-1:0]  wdata_q;
	logic [asc_pkg::DATA_W-1:0]  din_meta_q;
	logic [asc_pkg::DATA_W-1:0]  din_sync_q;
	logic                        rsp_valid_q;
	logic [asc_pkg::DATA_W-1:0]  rdata_q;

	asc_tmr_if #(.W(asc_pkg::CNT_W)) tmr ();

	asc_timer #(.W(asc_pkg::CNT_W)) u_timer (
		.mclk  (mclk),
		.rst_n (rst_sync_q),
		.tmr   (tmr.tmr)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Read data come from pins and are synchronised before use.
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			din_meta_q <= '0;
			din_sync_q <= '0;
		end else begin
			din_meta_q <= mem_data_in;
			din_sync_q <= din_meta_q;
		end
	end

	assign accept = req_valid && ready_q;

	always_comb begin
		tmr.load  = 1'b0;
		tmr.value = '0;
		case (state_q)
			asc_pkg::ST_IDLE, asc_pkg::ST_RNEXT: begin
				if (accept && !req_write) begin
					tmr.load  = 1'b1;
					tmr.value = asc_pkg::LD_READ;
				end
			end
			asc_pkg::ST_WSET: begin
				tmr.load  = 1'b1;
				tmr.value = asc_pkg::LD_FLOAT;
			end
			asc_pkg::ST_WFLOAT: begin
				if (tmr.done) begin
					tmr.load  = 1'b1;
					tmr.value = asc_pkg::LD_SETUP;
				end
			end
			default: begin
				tmr.load  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= asc_pkg::ST_IDLE;
		end else begin
			case (state_q)
				asc_pkg::ST_IDLE, asc_pkg::ST_RNEXT: begin
					if (accept) begin
						state_q <= req_write ? asc_pkg::ST_WSET
							: asc_pkg::ST_RACC;
					end else begin
						state_q <= asc_pkg::ST_IDLE;
					end
				end
				asc_pkg::ST_RACC: begin
					if (tmr.done) begin
						state_q <= asc_pkg::ST_RNEXT;
					end
				end
				asc_pkg::ST_WSET: begin
					state_q <= asc_pkg::ST_WFLOAT;
				end
				asc_pkg::ST_WFLOAT: begin
					if (tmr.done) begin
						state_q <= asc_pkg::ST_WDATA;
					end
				end
				asc_pkg::ST_WDATA: begin
					if (tmr.done) begin
						state_q <= asc_pkg::ST_WHOLD;
					end
				end
				default: begin
					state_q <= asc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ready_q <= 1'b1;
		end else if (accept) begin
			ready_q <= 1'b0;
		end else if ((state_q == asc_pkg::ST_RACC && tmr.done) ||
			state_q == asc_pkg::ST_WHOLD) begin
			ready_q <= 1'b1;
		end
	end

	// Address and select change together on a new access.
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sel_q   <= 1'b0;
			sel_n_q <= 1'b1;
			addr_q  <= '0;
			wdata_q <= '0;
		end else if (accept) begin
			sel_q   <= 1'b1;
			sel_n_q <= 1'b0;
			addr_q  <= req_addr;
			wdata_q <= req_wdata;
		end else if (state_q == asc_pkg::ST_RNEXT ||
			state_q == asc_pkg::ST_WHOLD) begin
			sel_q   <= 1'b0;
			sel_n_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			gate_n_q <= 1'b1;
		end else if (accept) begin
			gate_n_q <= req_write;
		end else if (state_q == asc_pkg::ST_RNEXT) begin
			gate_n_q <= 1'b1;
		end
	end

	// Strobe falls after address setup and rises to end the write.
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			we_n_q <= 1'b1;
		end else if (state_q == asc_pkg::ST_WSET) begin
			we_n_q <= 1'b0;
		end else if (state_q == asc_pkg::ST_WDATA && tmr.done) begin
			we_n_q <= 1'b1;
		end
	end

	// Data are driven only after the memory has floated its pins.
	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			doe_n_q <= 1'b1;
		end else if (state_q == asc_pkg::ST_WFLOAT && tmr.done) begin
			doe_n_q <= 1'b0;
		end else if (state_q == asc_pkg::ST_WHOLD) begin
			doe_n_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rsp_valid_q <= 1'b0;
			rdata_q     <= '0;
		end else begin
			rsp_valid_q <= state_q == asc_pkg::ST_RACC && tmr.done;
			if (state_q == asc_pkg::ST_RACC && tmr.done) begin
				rdata_q <= din_sync_q;
			end
		end
	end

	assign req_ready         = ready_q;
	assign rsp_valid         = rsp_valid_q;
	assign rsp_rdata         = rdata_q;
	assign chip_select_low_n = sel_n_q;
	assign chip_select_high  = sel_q;
	assign write_strobe_n    = we_n_q;
	assign output_gate_n     = gate_n_q;
	assign mem_addr          = addr_q;
	assign mem_data_out      = wdata_q;
	assign mem_data_oe_n     = doe_n_q;

	a_read_strobe_high: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		!gate_n_q |-> we_n_q && sel_q)
		else $error("output gate low without a clean read");
	a_write_selected: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		!we_n_q |-> sel_q && !chip_select_low_n && chip_select_high)
		else $error("write strobe low while deselected");
	a_drive_gate_high: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		!doe_n_q |-> gate_n_q && sel_q)
		else $error("data driven while the memory may drive");
	a_float_wait: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		$fell(we_n_q) |-> doe_n_q [*4] ##1 !doe_n_q)
		else $error("data driven before the float delay");
	a_strobe_width: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		$fell(we_n_q) |-> ##1 !we_n_q [*8] ##1 we_n_q)
		else $error("write strobe low time wrong");
	a_data_setup_hold: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		$rose(we_n_q) |-> !doe_n_q && sel_q && !$past(doe_n_q, 5)
			&& $stable(wdata_q) ##1 doe_n_q && !sel_q)
		else $error("write data setup or hold broken");
	a_addr_stable_read: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		state_q == asc_pkg::ST_RACC && $past(sel_q) |->
			$stable(addr_q) || $past(state_q) == asc_pkg::ST_RNEXT)
		else $error("address moved during a selected read");
	a_read_latency: assert property (
		@(posedge mclk) disable iff (!rst_sync_q)
		accept && !req_write |-> ##13 rsp_valid_q)
		else $error("read answer missing twelve edges after taking");
endmodule // asc_ctrl

// *** hdl/asc_pkg.sv ***
// Purpose: Shared constants for the static memory access controller.
// Assumes: A 200 MHz controller clock and an 8-bit asynchronous memory.
// Notes:   Cycle counts are derived from the times; waits round up.
package asc_pkg;
	localparam int CLK_PERIOD_NS    = 5;
	localparam int ADDR_W           = 21;
	localparam int DATA_W           = 8;
	localparam int CNT_W            = 4;
	localparam int SYNC_STAGES      = 2;

	// Memory timing in nanoseconds.
	localparam int T_READ_CYCLE_NS  = 45;
	localparam int T_FLOAT_NS       = 18;
	localparam int T_SETUP_NS       = 25;

	localparam int READ_CYC  = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Timer load values: a phase lasts load + 1 cycles.
	localparam logic [CNT_W-1:0] LD_READ  =
		CNT_W'(READ_CYC + SYNC_STAGES);
	localparam logic [CNT_W-1:0] LD_FLOAT = CNT_W'(FLOAT_CYC - 1);
	localparam logic [CNT_W-1:0] LD_SETUP = CNT_W'(SETUP_CYC - 1);

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_RACC   = 7'h02,
		ST_RNEXT  = 7'h04,
		ST_WSET   = 7'h08,
		ST_WFLOAT = 7'h10,
		ST_WDATA  = 7'h20,
		ST_WHOLD  = 7'h40
	} asc_state_t;
endpackage

// *** hdl/asc_tmr_if.sv ***
// Purpose: Carries load and done between the controller and its timer.
// Assumes: One clock domain.
// Notes:   None.
`timescale 1ns/1ps
interface asc_tmr_if #(parameter int W = 4);
	logic         load;
	logic [W-1:0] value;
	logic         done;
	modport ctl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface

// *** hdl/asc_timer.sv ***
// Purpose: Down counter that times the read access, float and data setup phases of a memory access.
// Assumes: Load and done are on the controller clock.
// Notes:   Done is high while the count stands at zero.
`timescale 1ns/1ps
module asc_timer #(
	parameter int W = 4
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	asc_tmr_if.tmr    tmr
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (tmr.load) begin
			cnt_q <= tmr.value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign tmr.done = (cnt_q == '0);

	a_timer_counts: assert property (@(posedge mclk) disable iff (!rst_n)
		tmr.load && tmr.value == W'(3) ##1 !tmr.load [*3]
		|=> tmr.done)
		else $error("timer did not reach zero after its load");
endmodule // asc_timer

// *** testbench/asc_mem_model.sv ***
// Purpose: Behavioural model of the 8-bit asynchronous memory.
// Assumes: Unwritten bytes read as the low address byte xor 5a.
// Notes:   Flags pin contention and late write data on rule_bad.
`timescale 1ns/1ps
module asc_mem_model #(
	parameter int ACC_NS   = 45,
	parameter int SETUP_NS = 25
) (
	input  wire logic        chip_select_low_n,
	input  wire logic        chip_select_high,
	input  wire logic        write_strobe_n,
	input  wire logic        output_gate_n,
	input  wire logic [20:0] mem_addr,
	input  wire logic [7:0]  mem_data_in,
	input  wire logic        mem_data_oe_n,
	output wire logic        dev_drive,
	output logic      [7:0]  dev_data,
	output logic             rule_bad
);
	logic [7:0] store   [0:(1<<21)-1];
	logic       written [0:(1<<21)-1];
	logic       sel;
	logic       wr_on;
	logic       wr_seen = 1'b0;
	int         gen     = 0;
	int         stamp   = -1;
	realtime    t_data  = 0;

	initial rule_bad = 1'b0;
	assign sel = !chip_select_low_n && chip_select_high;
	assign wr_on = sel && !write_strobe_n;
	// Pins drive only for a gated read; a deselected part idles in standby.
	assign dev_drive = sel && write_strobe_n && !output_gate_n;

	function automatic logic [7:0] peek(input logic [20:0] a);
		return (written[a] === 1'b1) ? store[a] : a[7:0] ^ 8'h5a;
	endfunction

	// Data shows a wrong pattern until the access time has passed.
	always @(mem_addr or sel or output_gate_n) begin
		gen = gen + 1;
		stamp <= #(ACC_NS) gen;
	end
	always @(stamp or gen or mem_addr or wr_on)
		dev_data = (stamp == gen) ? peek(mem_addr) : ~peek(mem_addr);
	always @(mem_data_in)
		t_data = $realtime;
	always @(posedge wr_on)
		wr_seen = 1'b1;
	// Whichever signal releases first ends the write and stores the byte.
	always @(negedge wr_on) begin
		if (wr_seen) begin
			store[mem_addr] = mem_data_in;
			written[mem_addr] = 1'b1;
			if ($realtime - t_data < SETUP_NS)
				rule_bad = 1'b1;
		end
	end
	always @(dev_drive or mem_data_oe_n)
		if (dev_drive && !mem_data_oe_n)
			rule_bad = 1'b1;
endmodule // asc_mem_model

// *** testbench/async_sram_access_control_bench.sv ***
// Purpose: Self-checking bench for the memory access controller.
// Assumes: Memory model with 45 ns access; inputs move 1 ns after edges.
// Notes:   Released data pins show a pattern that toggles every cycle.
`timescale 1ns/1ps
module async_sram_access_control_bench;
	logic        mclk      = 1'b0;
	logic        rst_n     = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [20:0] req_addr  = 21'h0;
	logic [7:0]  req_wdata = 8'h0;
	logic        req_ready, rsp_valid, chip_select_low_n, chip_select_high;
	logic        write_strobe_n, output_gate_n, mem_data_oe_n, dev_drive;
	logic        rule_bad;
	logic [20:0] mem_addr;
	logic [7:0]  rsp_rdata, mem_data_out, mem_data_in, dev_data;
	logic [7:0]  bus_last  = 8'h0;
	logic        pend      = 1'b0;
	logic        pend_w    = 1'b0;
	logic [20:0] pend_a    = 21'h0;
	int          errors    = 0;
	int          compares  = 0;
	int          cycles    = 0;

	asc_ctrl asc_ctrl_i (.mclk, .rst_n, .req_valid, .req_write, .req_addr,
		.req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .chip_select_low_n,
		.chip_select_high, .write_strobe_n, .output_gate_n, .mem_addr,
		.mem_data_out, .mem_data_oe_n, .mem_data_in);
	asc_mem_model asc_mem_model_i (.chip_select_low_n, .chip_select_high,
		.write_strobe_n, .output_gate_n, .mem_addr, .mem_data_in,
		.mem_data_oe_n, .dev_drive, .dev_data, .rule_bad);

	always @* begin
		if (!mem_data_oe_n)
			mem_data_in = mem_data_out;
		else if (dev_drive)
			mem_data_in = dev_data;
		else
			mem_data_in = ~bus_last;
	end
	always @(posedge mclk) bus_last <= mem_data_in;
	always #2.5 mclk = ~mclk;

	task automatic tally_and_finish;
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tick;
		@(posedge mclk);
		#1;
	endtask

	task automatic check(input string what, input logic [20:0] seen,
		input logic [20:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds the request until taken, then presents any pending one.
	task automatic req(input logic w, input logic [20:0] a,
		input logic [7:0] d);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1)
			tick();
		tick();
		req_valid = pend;
		req_write = pend_w;
		req_addr = pend_a;
		req_wdata = ~d;
	endtask

	task automatic rd(input logic [20:0] a, input logic [7:0] e);
		req(1'b0, a, 8'h0);
		for (int k = 1; k <= 12; k++) begin
			check("select", chip_select_low_n, 1'b0);
			check("gate", output_gate_n, 1'b0);
			check("strobe", write_strobe_n, 1'b1);
			check("address", mem_addr, a);
			tick();
			check("answer", rsp_valid, k == 12);
		end
		check("read byte", rsp_rdata, e);
		if (pend && !pend_w)
			check("held select", chip_select_low_n, 1'b0);
	endtask

	task automatic wr(input logic [20:0] a, input logic [7:0] d,
		input bit exact);
		req(1'b1, a, d);
		for (int j = 0; j < 12 && exact; j++) begin
			check("w select", chip_select_low_n, j >= 11);
			check("w select hi", chip_select_high, j <= 10);
			check("w strobe", write_strobe_n, !(j >= 1 && j <= 9));
			check("w drive", mem_data_oe_n, !(j >= 5 && j <= 10));
			check("w gate", output_gate_n, 1'b1);
			tick();
		end
		for (int j = 0; j < 40 && req_ready !== 1'b1; j++)
			tick();
		check("ready", req_ready, 1'b1);
	endtask

	task automatic sc_reset;
		check("rst select", chip_select_low_n, 1'b1);
		check("rst select hi", chip_select_high, 1'b0);
		check("rst drive", mem_data_oe_n, 1'b1);
		check("rst gate", output_gate_n, 1'b1);
		check("rst strobe", write_strobe_n, 1'b1);
	endtask

	task automatic sc_rw;
		wr(21'h000000, 8'ha5, 1'b1);
		wr(21'h1fffff, 8'h3c, 1'b1);
		rd(21'h000000, 8'ha5);
		rd(21'h1fffff, 8'h3c);
		rd(21'h001234, 8'h34 ^ 8'h5a);
	endtask

	task automatic sc_chain;
		pend = 1'b1;
		pend_a = 21'h1fffff;
		rd(21'h000000, 8'ha5);
		pend = 1'b0;
		rd(21'h1fffff, 8'h3c);
	endtask

	task automatic sc_turn;
		pend = 1'b1;
		pend_w = 1'b1;
		pend_a = 21'h0abcde;
		rd(21'h000000, 8'ha5);
		pend = 1'b0;
		pend_w = 1'b0;
		wr(21'h0abcde, 8'h96, 1'b0);
		rd(21'h0abcde, 8'h96);
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		#1;
		sc_reset();
		rst_n = 1'b1;
		repeat (3) tick();
		sc_rw();
		sc_chain();
		sc_turn();
		check("pin rules", rule_bad, 1'b0);
		tally_and_finish();
	end
endmodule // async_sram_access_control_bench
